// *** design/ssq_pkg.sv ***
package ssq_pkg;

   // Sequence geometry
   localparam int STEPS    = 16;
   localparam int OUTS     = 16;
   localparam int IDX_W    = 4;                  // Step index 0..15
   localparam int STEP_W   = 5;                  // Step number 1..16
   localparam int SET_W    = 14;                 // Settings up to 9999
   localparam int TIME_W   = SET_W + 1;          // Room for a +1 compare

   // Largest timebase or count setting accepted
   localparam logic [SET_W-1:0] MAX_SETTING = 14'h270f;

   // Step numbering and reset values
   localparam logic [IDX_W-1:0]  FIRST_IDX     = 4'h0;
   localparam logic [IDX_W-1:0]  FINAL_IDX     = 4'hf;
   localparam logic [STEP_W-1:0] FIRST_STEP    = 5'h01;
   localparam logic [STEP_W-1:0] FINAL_STEP    = 5'h10;
   localparam logic [SET_W-1:0]  ZERO_COUNT    = 14'h0000;
   localparam logic [SET_W-1:0]  ONE_COUNT     = 14'h0001;
   localparam logic [OUTS-1:0]   OUTS_OFF      = 16'h0000;

   // Base tick: 10 ms of a 250 MHz clock
   localparam int CLK_MHZ          = 250;
   localparam int BASE_TICK_MS     = 10;
   localparam int BASE_TICK_CYCLES = BASE_TICK_MS * 1000 * CLK_MHZ;

   // Sequencer variants
   typedef enum logic [1:0] {
      SSQ_TIMED_ONLY,
      SSQ_TIME_EVENT,
      SSQ_MASKED_BITS,
      SSQ_MASKED_WORD
   } ssq_variant_e;

   // Sequencer states
   typedef enum logic [1:0] {
      SSQ_PROGRAM,
      SSQ_RUN,
      SSQ_DONE
   } ssq_state_e;

endpackage

// *** design/ssq_tick_gen.sv ***
`timescale 1ns/10ps
module ssq_tick_gen
   import ssq_pkg::*;
#(
   parameter int CYCLES = BASE_TICK_CYCLES
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Scan tick
   output logic      tick
);

   localparam int CNT_W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
   localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

   logic [CNT_W-1:0] count;

   // Free running divider, one pulse per period
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= '0;
         tick  <= 1'b0;
      end else if (count == LAST) begin
         count <= '0;
         tick  <= 1'b1;
      end else begin
         count <= count + 1'b1;
         tick  <= 1'b0;
      end
   end

endmodule

// *** design/ssq_sequencer.sv ***
// Behaviour
// - Sixteen steps, each with a sixteen bit pattern; current pattern drives outputs.
// - One shared timebase, 0.01 to 99.99 s in 0.01 s units.
// - Each step has own counts; step time is 10 ms x timebase x counts.
// - Timebase and counts accept values up to 9999.
// - State is evaluated once per scan; finer timing has no effect.
// - Entering a step applies its pattern, then its event is sampled.
// - With event and time, counting advances only while the event is true.
// - Expired counts move to the next step with new outputs at once.
// - Each step transitions on time, event or both, mixed freely.
// - Partial sequences allowed; the last programmed step ends the cycle.
// - Timed variant uses time only; other three also use events.
// - Variants give bits or a word output, optionally with an output mask.
// - Four counters: counts in step, timer, preset step, current step.
// - Timer counts 10 ms units; counts holds counts elapsed in step.
// - Preset step counter changes only on reconfiguration, not operation.
// - Reset input forces the preset step; preset jumps to any step.
// - Last step done sets completion flag, holds last masked pattern.
// - Start and jog are ignored in the complete state.
// - Complete left only by reset or run entry; flag clears, preset step. The code also leaves it for program when RUN_MODE drops.
// - Start honored with reset off; start off freezes state and outputs.
// - Jog rising edge advances one step and clears timer; not timed variant.
// - Reset beats start; held reset stays at preset without timing.
// - Preset is step 1 to 16; run entry goes there with its pattern.
`timescale 1ns/10ps
module ssq_sequencer
   import ssq_pkg::*;
#(
   parameter int TICK_CYCLES = BASE_TICK_CYCLES
) (
   // Clock and reset
   input  wire logic                    MCLK,
   input  wire logic                    RESETN,
   // Control inputs
   input  wire logic                    RUN_MODE,
   input  wire logic                    START,
   input  wire logic                    JOG,
   input  wire logic                    SEQ_RESET,
   input  wire logic [STEPS-1:0]        EVENTS,
   // Configuration
   input  wire logic [1:0]              VARIANT,
   input  wire logic [SET_W-1:0]        TIMEBASE,
   input  wire logic [STEP_W-1:0]       PRESET_STEP,
   input  wire logic [STEP_W-1:0]       LAST_STEP,
   input  wire logic [STEPS*OUTS-1:0]   PATTERNS,
   input  wire logic [STEPS*SET_W-1:0]  COUNTS_PER_STEP,
   input  wire logic [STEPS-1:0]        USE_TIME,
   input  wire logic [STEPS-1:0]        USE_EVENT,
   input  wire logic [OUTS-1:0]         OUT_MASK,
   // Sequencer outputs
   output logic [OUTS-1:0]              OUTPUTS,
   output logic                         SCAN_TICK,
   // Monitoring counters
   output logic [SET_W-1:0]             STEP_COUNTS_COUNTER,
   output logic [SET_W-1:0]             STEP_TIMER_COUNTER,
   output logic [STEP_W-1:0]            PRESET_STEP_COUNTER,
   output logic [STEP_W-1:0]            CURRENT_STEP_COUNTER,
   output logic                         CYCLE_DONE_FLAG
);

   // Step number 1..16 to index; out of range numbers fall back to step 1
   function automatic logic [IDX_W-1:0] step_idx(input logic [STEP_W-1:0] n);
      if (n < FIRST_STEP || n > FINAL_STEP)
         step_idx = FIRST_IDX;
      else
         step_idx = IDX_W'(n - FIRST_STEP);
   endfunction

   // Programmed counts of one step
   function automatic logic [SET_W-1:0] counts_of(input logic [IDX_W-1:0] i);
      counts_of = COUNTS_PER_STEP[i*SET_W +: SET_W];
   endfunction

   // Pattern of one step as shown on the outputs, mask applied if offered
   function automatic logic [OUTS-1:0] shown(input logic [IDX_W-1:0] i);
      logic [OUTS-1:0] p;
      p = PATTERNS[i*OUTS +: OUTS];
      if (VARIANT == SSQ_MASKED_BITS || VARIANT == SSQ_MASKED_WORD)
         shown = p & OUT_MASK;
      else
         shown = p;
   endfunction

   ssq_state_e       state;
   ssq_state_e       next_state;
   logic [IDX_W-1:0] idx;
   logic [IDX_W-1:0] next_idx;
   logic [IDX_W-1:0] preset;
   logic [IDX_W-1:0] next_preset;
   logic [SET_W-1:0] timer;
   logic [SET_W-1:0] next_timer;
   logic [SET_W-1:0] counts;
   logic [SET_W-1:0] next_counts;
   logic             tick;
   logic             jog_prev;
   logic             run_prev;
   logic             jog_rise;
   logic             run_rise;
   logic             timed_only;
   logic             use_evt;
   logic             use_time;
   logic             evt;
   logic             tb_end;
   logic             cnt_end;
   logic             advance;
   logic [IDX_W-1:0] last_idx;

   // Scan tick, one evaluation per 10 ms
   ssq_tick_gen #(
      .CYCLES (TICK_CYCLES)
   ) u_tick (
      .clk    (MCLK),
      .rst_n  (RESETN),
      .tick   (tick)
   );

   // Step condition decode for the current step
   assign timed_only = (VARIANT == SSQ_TIMED_ONLY);
   assign use_evt    = !timed_only && USE_EVENT[idx];
   assign use_time   = !use_evt || USE_TIME[idx];
   assign evt        = EVENTS[idx];
   assign last_idx   = step_idx(LAST_STEP);
   // Inputs seen only at scans, so a jog shorter than a scan can be missed
   assign jog_rise   = JOG && !jog_prev;
   assign run_rise   = RUN_MODE && !run_prev;
   // Timebase of zero behaves as one base tick per count
   assign tb_end     = (TIME_W'(timer) + 1'b1)
                       >= TIME_W'(TIMEBASE);
   assign cnt_end    = (TIME_W'(counts) + 1'b1)
                       >= TIME_W'(counts_of(idx));

   // Next state of the sequencer for the coming scan
   always_comb begin
      next_state  = state;
      next_idx    = idx;
      next_timer  = timer;
      next_counts = counts;
      next_preset = preset;
      advance     = 1'b0;
      if (!RUN_MODE) begin
         next_state = SSQ_PROGRAM;
      end else if (run_rise) begin
         next_preset = step_idx(PRESET_STEP);
         next_idx    = step_idx(PRESET_STEP);
         next_state  = SSQ_RUN;
         next_timer  = ZERO_COUNT;
         next_counts = ZERO_COUNT;
      end else if (SEQ_RESET) begin
         next_idx    = preset;
         next_state  = SSQ_RUN;
         next_timer  = ZERO_COUNT;
         next_counts = ZERO_COUNT;
      end else begin
         case (state)
            SSQ_RUN: begin
               if (jog_rise && !timed_only) begin
                  advance = 1'b1;
               end else if (START) begin
                  if (!use_time) begin
                     advance = evt;
                  end else if (!use_evt || evt) begin
                     if (tb_end) begin
                        next_timer = ZERO_COUNT;
                        if (cnt_end)
                           advance = 1'b1;
                        else
                           next_counts = counts + ONE_COUNT;
                     end else begin
                        next_timer = timer + ONE_COUNT;
                     end
                  end
               end
            end
            SSQ_DONE: begin
               next_state = SSQ_DONE;
            end
            default: begin
               next_state = state;
            end
         endcase
      end
      // Step change clears the step timing; last step ends the cycle
      if (advance) begin
         next_timer  = ZERO_COUNT;
         next_counts = ZERO_COUNT;
         if (idx == last_idx || idx == FINAL_IDX)
            next_state = SSQ_DONE;
         else
            next_idx = idx + 1'b1;
      end
   end

   // Sequencer state, moved only at scan ticks
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         state  <= SSQ_PROGRAM;
         idx    <= FIRST_IDX;
         timer  <= ZERO_COUNT;
         counts <= ZERO_COUNT;
      end else if (tick) begin
         state  <= next_state;
         idx    <= next_idx;
         timer  <= next_timer;
         counts <= next_counts;
      end
   end

   // Preset step follows configuration only when run mode is entered
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN)
         preset <= FIRST_IDX;
      else if (tick)
         preset <= next_preset;
   end

   // Input history for edge detection, sampled at each scan
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         jog_prev <= 1'b0;
         run_prev <= 1'b0;
      end else if (tick) begin
         jog_prev <= JOG;
         run_prev <= RUN_MODE;
      end
   end

   // Outputs take the new step's pattern in the same scan; off in program
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN)
         OUTPUTS <= OUTS_OFF;
      else if (tick && next_state == SSQ_PROGRAM)
         OUTPUTS <= OUTS_OFF;
      else if (tick)
         OUTPUTS <= shown(next_idx);
   end

   // Monitoring counters, completion flag and scan tick
   assign STEP_COUNTS_COUNTER  = counts;
   assign STEP_TIMER_COUNTER   = timer;
   assign PRESET_STEP_COUNTER  = STEP_W'(preset) + FIRST_STEP;
   assign CURRENT_STEP_COUNTER = STEP_W'(idx) + FIRST_STEP;
   assign CYCLE_DONE_FLAG      = (state == SSQ_DONE);
   assign SCAN_TICK            = tick;

   // Checks
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RESETN);

   logic live;
   assign live = tick && RUN_MODE && !run_rise && !SEQ_RESET;

   no_tick_hold_a: assert property (
      !tick |=> $stable(idx) && $stable(timer) && $stable(counts))
      else $error("state moved between scans");

   reset_preset_a: assert property (
      tick && RUN_MODE && !run_rise && SEQ_RESET
      |=> idx == preset && timer == 0 && counts == 0 && !CYCLE_DONE_FLAG)
      else $error("reset did not hold preset step");

   done_hold_a: assert property (
      live && state == SSQ_DONE |=> CYCLE_DONE_FLAG && $stable(idx))
      else $error("complete state left without reset");

   start_freeze_a: assert property (
      live && state == SSQ_RUN && !START && !(jog_rise && !timed_only)
      |=> $stable(idx) && $stable(timer) && $stable(OUTPUTS))
      else $error("sequencer moved while stopped");

   jog_step_a: assert property (
      live && state == SSQ_RUN && jog_rise && !timed_only
      && idx != last_idx && idx != FINAL_IDX
      |=> idx == $past(idx) + 1'b1 && timer == 0 && counts == 0)
      else $error("jog did not advance one step");

   event_gate_a: assert property (
      live && state == SSQ_RUN && START && use_evt && use_time && !evt
      && !jog_rise |=> $stable(timer) && $stable(counts) && $stable(idx))
      else $error("timing ran with event false");

   out_pattern_a: assert property (
      tick && RUN_MODE |=> OUTPUTS == shown(idx))
      else $error("outputs differ from current step pattern");

   preset_keep_a: assert property (
      !(tick && run_rise) |=> $stable(preset))
      else $error("preset step changed by operation");

   run_entry_a: assert property (
      tick && run_rise |=> idx == step_idx($past(PRESET_STEP))
      && state == SSQ_RUN && timer == 0)
      else $error("run entry did not go to preset step");

   // Main scenarios
   done_reached_c: cover property (tick && state == SSQ_RUN
      && next_state == SSQ_DONE);
   jog_used_c: cover property (live && state == SSQ_RUN && jog_rise
      && !timed_only);
   done_reset_c: cover property (tick && state == SSQ_DONE && SEQ_RESET);
   count_step_c: cover property (live && START && tb_end && !cnt_end);

endmodule

// *** testbench/ssq_ctrl_model.sv ***
`timescale 1ns/10ps
module ssq_ctrl_model
   import ssq_pkg::*;
(
   // Clock
   input  wire logic         clk,
   // Control levels toward the sequencer
   output logic              run_mode,
   output logic              start,
   output logic              jog,
   output logic              seq_reset,
   output logic [STEPS-1:0]  events
);
   // Quiet levels at time zero: program mode, nothing asked
   initial begin
      run_mode  = 1'b0;
      start     = 1'b0;
      jog       = 1'b0;
      seq_reset = 1'b0;
      events    = 16'h0000;
   end

   // Falling edge only, so each scan edge sees settled levels
   task automatic drive(input logic r, input logic s, input logic j,
                        input logic x, input logic [STEPS-1:0] e);
      @(negedge clk);
      run_mode  = r;
      start     = s;
      jog       = j;
      seq_reset = x;
      events    = e;
   endtask
endmodule

// *** testbench/step_sequencer_16x16_tb.sv ***
`timescale 1ns/10ps
module step_sequencer_16x16_tb
   import ssq_pkg::*;
;
   // Short scan period keeps the run brief
   localparam int TICKS = 8;
   logic                    MCLK = 1'b0;
   logic                    RESETN = 1'b0;
   logic                    RUN_MODE, START, JOG, SEQ_RESET;
   logic [STEPS-1:0]        EVENTS;
   logic [1:0]              VARIANT = 2'h1;
   logic [SET_W-1:0]        TIMEBASE = 14'h0002;
   logic [STEP_W-1:0]       PRESET_STEP = 5'h03;
   logic [STEP_W-1:0]       LAST_STEP = 5'h05;
   logic [STEPS*OUTS-1:0]   PATTERNS;
   logic [STEPS*SET_W-1:0]  COUNTS_PER_STEP;
   logic [STEPS-1:0]        USE_TIME = 16'hffff;
   logic [STEPS-1:0]        USE_EVENT = 16'h0000;
   logic [OUTS-1:0]         OUT_MASK = 16'hffff;
   logic [OUTS-1:0]         OUTPUTS;
   logic                    SCAN_TICK, CYCLE_DONE_FLAG;
   logic [SET_W-1:0]        STEP_COUNTS_COUNTER, STEP_TIMER_COUNTER;
   logic [STEP_W-1:0]       PRESET_STEP_COUNTER, CURRENT_STEP_COUNTER;
   int                      n_mismatch = 0;
   int                      checks_done = 0;

   // Clock
   always #2 MCLK = ~MCLK;

   ssq_ctrl_model ctrl (.clk(MCLK), .run_mode(RUN_MODE), .start(START),
      .jog(JOG), .seq_reset(SEQ_RESET), .events(EVENTS));

   ssq_sequencer #(.TICK_CYCLES(TICKS)) dut (.MCLK(MCLK), .RESETN(RESETN),
      .RUN_MODE(RUN_MODE), .START(START), .JOG(JOG), .SEQ_RESET(SEQ_RESET),
      .EVENTS(EVENTS), .VARIANT(VARIANT), .TIMEBASE(TIMEBASE),
      .PRESET_STEP(PRESET_STEP), .LAST_STEP(LAST_STEP),
      .PATTERNS(PATTERNS), .COUNTS_PER_STEP(COUNTS_PER_STEP),
      .USE_TIME(USE_TIME), .USE_EVENT(USE_EVENT), .OUT_MASK(OUT_MASK),
      .OUTPUTS(OUTPUTS), .SCAN_TICK(SCAN_TICK),
      .STEP_COUNTS_COUNTER(STEP_COUNTS_COUNTER),
      .STEP_TIMER_COUNTER(STEP_TIMER_COUNTER),
      .PRESET_STEP_COUNTER(PRESET_STEP_COUNTER),
      .CURRENT_STEP_COUNTER(CURRENT_STEP_COUNTER),
      .CYCLE_DONE_FLAG(CYCLE_DONE_FLAG));

   // Distinct pattern per step so a wrong step shows on the outputs
   function automatic logic [15:0] pat(input int k);
      return 16'(k * 16'h0111) ^ 16'h8000;
   endfunction

   // Single closing point for pass, fail and hang
   task automatic complete_run();
      $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Return just after the n-th scan edge has landed
   task automatic scans(input int n);
      int b;
      for (int i = 0; i < n; i++) begin
         b = 0;
         while (SCAN_TICK !== 1'b1) begin
            @(negedge MCLK);
            b++;
            if (b > 4 * TICKS) begin
               n_mismatch++;
               $display("wrong value at %0t: no scan tick", $time);
               complete_run();
            end
         end
         @(negedge MCLK);
      end
   endtask

   task automatic expect_state(input logic [4:0] s, input logic [13:0] c,
                               input logic [13:0] t, input logic [15:0] o);
      check({11'h000, CURRENT_STEP_COUNTER}, {11'h000, s});
      check({2'h0, STEP_COUNTS_COUNTER}, {2'h0, c});
      check({2'h0, STEP_TIMER_COUNTER}, {2'h0, t});
      check(OUTPUTS, o);
   endtask

   // Program mode keeps outputs off; run entry lands on the preset step
   task automatic t_entry();
      scans(1);
      check(OUTPUTS, OUTS_OFF);
      ctrl.drive(1'b1, 1'b0, 1'b0, 1'b0, 16'h0000);
      scans(1);
      expect_state(5'h03, 14'h0, 14'h0, pat(3));
      check({11'h000, PRESET_STEP_COUNTER}, 16'h0003);
   endtask

   // Timebase 2 and counts 2 give exactly four scans in the step
   task automatic t_timed();
      ctrl.drive(1'b1, 1'b1, 1'b0, 1'b0, 16'h0000);
      scans(3);
      expect_state(5'h03, 14'h1, 14'h1, pat(3));
      scans(1);
      expect_state(5'h04, 14'h0, 14'h0, pat(4));
   endtask

   // Start low mid-count must hold timer and step
   task automatic t_freeze();
      scans(1);
      ctrl.drive(1'b1, 1'b0, 1'b0, 1'b0, 16'h0000);
      scans(3);
      expect_state(5'h04, 14'h0, 14'h1, pat(4));
   endtask

   // Jog while stopped advances and clears the timer
   task automatic t_jog();
      ctrl.drive(1'b1, 1'b0, 1'b1, 1'b0, 16'h0000);
      scans(1);
      expect_state(5'h05, 14'h0, 14'h0, pat(5));
      ctrl.drive(1'b1, 1'b0, 1'b0, 1'b0, 16'h0000);
      scans(1);
   endtask

   // Reset with start high parks on the preset step without timing
   task automatic t_reset();
      ctrl.drive(1'b1, 1'b1, 1'b0, 1'b1, 16'h0000);
      scans(2);
      expect_state(5'h03, 14'h0, 14'h0, pat(3));
      ctrl.drive(1'b1, 1'b0, 1'b0, 1'b0, 16'h0000);
   endtask

   // Step 3 time and event, step 4 event only
   task automatic t_event();
      @(negedge MCLK);
      USE_EVENT = 16'h000c;
      USE_TIME = 16'hfff7;
      ctrl.drive(1'b1, 1'b1, 1'b0, 1'b0, 16'h0000);
      scans(4);
      expect_state(5'h03, 14'h0, 14'h0, pat(3));
      ctrl.drive(1'b1, 1'b1, 1'b0, 1'b0, 16'h0004);
      scans(4);
      expect_state(5'h04, 14'h0, 14'h0, pat(4));
      ctrl.drive(1'b1, 1'b1, 1'b0, 1'b0, 16'h0008);
      scans(1);
      expect_state(5'h05, 14'h0, 14'h0, pat(5));
   endtask

   // Last step ends the cycle; jog ignored; reset clears the flag
   task automatic t_done();
      ctrl.drive(1'b1, 1'b1, 1'b0, 1'b0, 16'h0000);
      scans(4);
      check({15'h0000, CYCLE_DONE_FLAG}, 16'h0001);
      check(OUTPUTS, pat(5));
      ctrl.drive(1'b1, 1'b1, 1'b1, 1'b0, 16'h0000);
      scans(1);
      check({11'h000, CURRENT_STEP_COUNTER}, 16'h0005);
      ctrl.drive(1'b1, 1'b1, 1'b0, 1'b1, 16'h0000);
      scans(1);
      check({15'h0000, CYCLE_DONE_FLAG}, 16'h0000);
      check({11'h000, CURRENT_STEP_COUNTER}, 16'h0003);
      ctrl.drive(1'b1, 1'b0, 1'b0, 1'b0, 16'h0000);
   endtask

   // Masked variant gates disabled outputs; started but gated by its event
   task automatic t_mask();
      ctrl.drive(1'b1, 1'b1, 1'b0, 1'b0, 16'h0000);
      VARIANT = 2'h2;
      OUT_MASK = 16'h00ff;
      scans(2);
      check(OUTPUTS, pat(3) & 16'h00ff);
   endtask

   // Main sequence
   initial begin
      for (int k = 1; k <= STEPS; k++) begin
         PATTERNS[(k-1)*OUTS +: OUTS] = pat(k);
         COUNTS_PER_STEP[(k-1)*SET_W +: SET_W] = 14'h0002;
      end
      repeat (12) @(negedge MCLK);
      RESETN = 1'b1;
      t_entry();
      t_timed();
      t_freeze();
      t_jog();
      t_reset();
      t_event();
      t_done();
      t_mask();
      complete_run();
   end
endmodule
